// [boiler_limit_override.sv]
// Hot-water high limit, anticondensation and outlet rise-rate limit with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module boiler_limit_override #(
    parameter int SAMPLE_CYCLES = boiler_limit_pkg::SAMPLE_CYC,
    parameter int SEC_CYCLES    = boiler_limit_pkg::SEC_CYC
) (
    // Clock and reset
    input  wire logic                              clk_sys_i,
    input  wire logic                              rst_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]                        s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [7:0]                        s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    // Sensors and burner state
    input  wire boiler_limit_pkg::temps_t          temps_i,
    input  wire boiler_limit_pkg::demand_src_t     demand_src_i,
    input  wire logic                              firing_i,
    input  wire boiler_limit_pkg::pump_req_t       pump_req_i,
    input  wire logic                              ac_rate_win_i,
    // To burner sequencer, rate arbiter and pumps
    output logic                                   lockout_o,
    output logic                                   recycle_hold_o,
    output logic                                   hw_suspend_o,
    output logic                                   safety_limit_o,
    output logic                                   rise_alert_o,
    output logic                                   ac_rate_req_o,
    output logic                                   ac_rate_sel_hw_o,
    output logic                                   ac_rate_apply_o,
    output logic                                   heat_pump_off_o,
    output logic                                   hw_pump_off_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_ff;
    logic [31:0] hw_lim_ff;
    logic [31:0] ac_sp_ff;
    logic [31:0] rise_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        do_write;
    logic [31:0] status;

    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_got_ff && w_got_ff && !s_axi_bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (do_write) begin
                aw_got_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (do_write) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff   <= boiler_limit_pkg::CTRL_RST;
            hw_lim_ff <= 32'h0000_0000;
            ac_sp_ff  <= 32'h0000_0000;
            rise_ff   <= 32'h0000_0000;
        end else if (do_write) begin
            unique case (awaddr_ff[7:2])
                boiler_limit_pkg::OFS_CTRL[7:2]:
                    ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff) & boiler_limit_pkg::CTRL_MASK;
                boiler_limit_pkg::OFS_HW_LIM[7:2]: hw_lim_ff <= merge(hw_lim_ff, wdata_ff, wstrb_ff);
                boiler_limit_pkg::OFS_AC_SP[7:2]:  ac_sp_ff  <= merge(ac_sp_ff, wdata_ff, wstrb_ff);
                boiler_limit_pkg::OFS_RISE[7:2]:   rise_ff   <= merge(rise_ff, wdata_ff, wstrb_ff);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff <= boiler_limit_pkg::OFS_RISE) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            unique case (s_axi_araddr[7:2])
                boiler_limit_pkg::OFS_CTRL[7:2]:   s_axi_rdata <= ctrl_ff;
                boiler_limit_pkg::OFS_HW_LIM[7:2]: s_axi_rdata <= hw_lim_ff;
                boiler_limit_pkg::OFS_AC_SP[7:2]:  s_axi_rdata <= ac_sp_ff;
                boiler_limit_pkg::OFS_RISE[7:2]:   s_axi_rdata <= rise_ff;
                boiler_limit_pkg::OFS_STATUS[7:2]: s_axi_rdata <= status;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings
    logic signed [11:0] hw_sp;
    logic signed [11:0] heat_ac_sp;
    logic signed [11:0] hw_ac_sp;
    logic signed [11:0] rise_lim;
    logic [15:0]        rise_delay_s;
    boiler_limit_pkg::hw_resp_t hw_resp;

    assign hw_sp        = hw_lim_ff[11:0];
    assign heat_ac_sp   = ac_sp_ff[11:0];
    assign hw_ac_sp     = ac_sp_ff[27:16];
    assign rise_lim     = rise_ff[11:0];
    // Delay held as minutes (bits 23:16) and seconds (bits 31:24)
    assign rise_delay_s = 16'(rise_ff[23:16]) * 16'd60 + 16'(rise_ff[31:24]);
    assign hw_resp      = boiler_limit_pkg::hw_resp_t'(
                          ctrl_ff[boiler_limit_pkg::CTRL_HW_RESP_LO +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // Hot-water high limit
    logic hw_lim_act_ff;
    logic hw_lock_ff;
    logic hw_hit;
    logic hw_clear;
    logic hw_en;

    assign hw_en    = ctrl_ff[boiler_limit_pkg::CTRL_HW_LIM_EN];
    assign hw_hit   = hw_en && (temps_i.hot_water >= hw_sp);
    assign hw_clear = temps_i.hot_water < (hw_sp - $signed(boiler_limit_pkg::HW_BAND_DEGF));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_lim_act_ff <= 1'b0;
        end else if (!hw_en) begin
            hw_lim_act_ff <= 1'b0;
        end else if (hw_hit) begin
            hw_lim_act_ff <= 1'b1;
        end else if (hw_clear) begin
            hw_lim_act_ff <= 1'b0;
        end
    end

    // Lockout stays latched; only a reset ends it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_lock_ff <= 1'b0;
        end else if (hw_hit && hw_resp == boiler_limit_pkg::RESP_LOCKOUT) begin
            hw_lock_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Anticondensation
    logic heat_ac_ff;
    logic hw_ac_ff;
    logic heat_fire;
    logic hw_src;

    assign heat_fire = firing_i && (demand_src_i == boiler_limit_pkg::SRC_CENTRAL ||
                       demand_src_i == boiler_limit_pkg::SRC_LEADLAG);
    assign hw_src = firing_i && demand_src_i == boiler_limit_pkg::SRC_HOTWATER;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            heat_ac_ff <= 1'b0;
        end else if (!(ctrl_ff[boiler_limit_pkg::CTRL_HEAT_AC_EN] && heat_fire)) begin
            heat_ac_ff <= 1'b0;
        end else if (temps_i.outlet < heat_ac_sp) begin
            heat_ac_ff <= 1'b1;
        end else if (temps_i.central_src >=
                     heat_ac_sp + $signed(boiler_limit_pkg::AC_HYST_DEGF)) begin
            heat_ac_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_ac_ff <= 1'b0;
        end else if (!(ctrl_ff[boiler_limit_pkg::CTRL_HW_AC_EN] && hw_src)) begin
            hw_ac_ff <= 1'b0;
        end else if (temps_i.outlet < hw_ac_sp) begin
            hw_ac_ff <= 1'b1;
        end else if (temps_i.outlet >=
                     hw_ac_sp + $signed(boiler_limit_pkg::AC_HYST_DEGF)) begin
            hw_ac_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outlet rise rate
    logic [31:0]        samp_cnt_ff;
    logic signed [11:0] prev_ff;
    logic               samp_valid_ff;
    logic               rise_hold_ff;
    logic [31:0]        sec_cnt_ff;
    logic [15:0]        hold_s_ff;
    logic signed [15:0] rate;
    logic               tick;
    logic               rise_en;

    assign rise_en = ctrl_ff[boiler_limit_pkg::CTRL_RISE_EN];
    assign tick    = samp_cnt_ff == 32'(SAMPLE_CYCLES - 1);
    assign rate    = 16'(temps_i.outlet - prev_ff) * 16'(boiler_limit_pkg::SAMPLES_PER_MIN);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            samp_cnt_ff   <= 32'h0000_0000;
            prev_ff       <= 12'sh000;
            samp_valid_ff <= 1'b0;
        end else if (!rise_en) begin
            samp_cnt_ff   <= 32'h0000_0000;
            samp_valid_ff <= 1'b0;
        end else begin
            samp_cnt_ff <= tick ? 32'h0000_0000 : samp_cnt_ff + 32'h0000_0001;
            if (tick) begin
                prev_ff       <= temps_i.outlet;
                samp_valid_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_hold_ff <= 1'b0;
            rise_alert_o <= 1'b0;
            sec_cnt_ff   <= 32'h0000_0000;
            hold_s_ff    <= 16'h0000;
        end else begin
            rise_alert_o <= 1'b0;
            if (rise_en && tick && samp_valid_ff && rate > 16'(rise_lim)) begin
                rise_hold_ff <= 1'b1;
                rise_alert_o <= 1'b1;
                sec_cnt_ff   <= 32'h0000_0000;
                hold_s_ff    <= rise_delay_s;
            end else if (rise_hold_ff) begin
                if (hold_s_ff == 16'h0000) begin
                    rise_hold_ff <= 1'b0;
                end else if (sec_cnt_ff == 32'(SEC_CYCLES - 1)) begin
                    sec_cnt_ff <= 32'h0000_0000;
                    hold_s_ff  <= hold_s_ff - 16'h0001;
                end else begin
                    sec_cnt_ff <= sec_cnt_ff + 32'h0000_0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic hw_lim_pump_on;

    // High limit in force asks the central-heat pump to keep running
    assign hw_lim_pump_on = hw_lim_act_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lockout_o        <= 1'b0;
            recycle_hold_o   <= 1'b0;
            hw_suspend_o     <= 1'b0;
            safety_limit_o   <= 1'b0;
            ac_rate_req_o    <= 1'b0;
            ac_rate_sel_hw_o <= 1'b0;
            ac_rate_apply_o  <= 1'b0;
            heat_pump_off_o  <= 1'b0;
            hw_pump_off_o    <= 1'b0;
        end else begin
            lockout_o      <= hw_lock_ff;
            recycle_hold_o <= (hw_lim_act_ff && hw_resp == boiler_limit_pkg::RESP_RECYCLE)
                              || rise_hold_ff;
            hw_suspend_o   <= hw_lim_act_ff && hw_resp == boiler_limit_pkg::RESP_SUSPEND;
            safety_limit_o <= hw_en && (hw_resp == boiler_limit_pkg::RESP_LOCKOUT ||
                              hw_resp == boiler_limit_pkg::RESP_RECYCLE);
            ac_rate_req_o    <= heat_ac_ff || hw_ac_ff;
            ac_rate_sel_hw_o <= hw_ac_ff;
            ac_rate_apply_o  <= (heat_ac_ff || hw_ac_ff) && ac_rate_win_i;
            heat_pump_off_o <= heat_ac_ff && ctrl_ff[boiler_limit_pkg::CTRL_HEAT_AC_FOFF] &&
                               !(pump_req_i.frost_heat || pump_req_i.outlet_limit_heat ||
                                 hw_lim_pump_on);
            hw_pump_off_o  <= hw_lim_act_ff ||
                              (hw_ac_ff && ctrl_ff[boiler_limit_pkg::CTRL_HW_AC_FOFF] &&
                               !pump_req_i.frost_hw);
        end
    end

    assign status = {24'h000000, 1'b0, rise_hold_ff, hw_ac_ff, heat_ac_ff,
                     heat_pump_off_o, hw_pump_off_o, hw_lock_ff, hw_lim_act_ff};

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_hw_pump_forced: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hw_lim_act_ff |=> hw_pump_off_o) else $error("hot-water pump not forced off");
    a_hw_lim_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !hw_en |=> !hw_lim_act_ff) else $error("limit active while disabled");
    a_hw_lim_trigger: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hw_hit |=> hw_lim_act_ff) else $error("limit not latched on trigger");
    a_lockout_stays: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hw_hit && hw_resp == boiler_limit_pkg::RESP_LOCKOUT |-> ##2 lockout_o[*3])
        else $error("lockout not held");
    a_ac_needs_fire: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !firing_i |=> !heat_ac_ff && !hw_ac_ff) else $error("override without firing");
    a_heat_pump_prio: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        pump_req_i.frost_heat |=> !heat_pump_off_o) else $error("frost pump overridden");
    a_rate_win: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ac_rate_win_i |=> !ac_rate_apply_o) else $error("rate applied without win");
    a_rise_alert: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rise_alert_o |-> rise_hold_ff ##1 recycle_hold_o)
        else $error("alert without hold");
    a_rise_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !rise_en |=> !rise_alert_o) else $error("alert while disabled");

endmodule : boiler_limit_override
`default_nettype wire

// [boiler_limit_pkg.sv]
// Package: register map, field layouts, constants and carriers for the limit and override block
package boiler_limit_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_HW_LIM   = 8'h04;
    localparam logic [7:0] OFS_AC_SP    = 8'h08;
    localparam logic [7:0] OFS_RISE     = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;

    // Control register fields
    localparam int CTRL_HW_LIM_EN   = 0;
    localparam int CTRL_HW_RESP_LO  = 1;
    localparam int CTRL_HEAT_AC_EN  = 3;
    localparam int CTRL_HW_AC_EN    = 4;
    localparam int CTRL_HEAT_AC_FOFF = 5;
    localparam int CTRL_HW_AC_FOFF  = 6;
    localparam int CTRL_RISE_EN     = 7;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_00FF;

    // Temperatures are whole degrees F, two's complement, 12 bits
    localparam int TW = 12;
    localparam logic [TW-1:0] HW_BAND_DEGF = 12'h005;
    localparam logic [TW-1:0] AC_HYST_DEGF = 12'h004;

    // Rise-rate sampling: one sample every 6 s, ten samples per minute
    localparam int  SAMPLE_MS       = 6000;
    localparam int  CLK_MHZ         = 200;
    localparam int  SAMPLE_CYC      = SAMPLE_MS * 1000 * CLK_MHZ;
    localparam int  SAMPLES_PER_MIN = 10;
    localparam int  SEC_MS          = 1000;
    localparam int  SEC_CYC         = SEC_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        RESP_LOCKOUT = 2'b00,
        RESP_RECYCLE = 2'b01,
        RESP_SUSPEND = 2'b10
    } hw_resp_t;

    typedef enum logic [1:0] {
        SRC_NONE     = 2'b00,
        SRC_CENTRAL  = 2'b01,
        SRC_HOTWATER = 2'b10,
        SRC_LEADLAG  = 2'b11
    } demand_src_t;

    typedef struct packed {
        logic signed [TW-1:0] hot_water;
        logic signed [TW-1:0] outlet;
        logic signed [TW-1:0] central_src;
    } temps_t;

    typedef struct packed {
        logic frost_heat;
        logic frost_hw;
        logic outlet_limit_heat;
    } pump_req_t;

endpackage : boiler_limit_pkg

// [rate_arbiter_model.sv]
// Behavioural firing-rate arbiter facing the anticondensation request
`timescale 1ns/1ps
`default_nettype none
module rate_arbiter_model (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Requests from the block and from rival overrides
    input  wire logic ac_rate_req_i,
    input  wire logic other_override_i,
    // Grant back to the block
    output logic      ac_rate_win_o
);
    // A rival rate-reducing override always beats anticondensation
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) ac_rate_win_o <= 1'b0;
        else ac_rate_win_o <= ac_rate_req_i & ~other_override_i;
    end
endmodule : rate_arbiter_model
`default_nettype wire

// [boiler_limit_override_tb.sv]
// Self-checking testbench for the limit and override block
`timescale 1ns/1ps
`default_nettype none
module boiler_limit_override_tb;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    boiler_limit_pkg::temps_t temps;
    boiler_limit_pkg::demand_src_t src;
    boiler_limit_pkg::pump_req_t preq;
    logic firing, other_ovr, win, lockout, rhold, susp, safety, alert;
    logic req, sel_hw, apply, heat_off, hw_off, seen_alert;
    logic [3:0] wstrb;
    int failures = 0;
    int total_checks = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;
    // Alert is a single-cycle pulse, so it is caught by a sticky flag
    always @(posedge clk_sys_i) if (alert === 1'b1) seen_alert <= 1'b1;

    // Short counts keep the rise-rate run brief: 20-cycle sample, 4-cycle second
    boiler_limit_override #(.SAMPLE_CYCLES(20), .SEC_CYCLES(4)) i_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .temps_i(temps),
        .demand_src_i(src), .firing_i(firing), .pump_req_i(preq), .ac_rate_win_i(win),
        .lockout_o(lockout), .recycle_hold_o(rhold), .hw_suspend_o(susp),
        .safety_limit_o(safety), .rise_alert_o(alert), .ac_rate_req_o(req),
        .ac_rate_sel_hw_o(sel_hw), .ac_rate_apply_o(apply), .heat_pump_off_o(heat_off),
        .hw_pump_off_o(hw_off));
    rate_arbiter_model i_arb (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .ac_rate_req_i(req), .other_override_i(other_ovr), .ac_rate_win_o(win));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(32'(bresp), 32'h0000_0000);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_hw_recycle;
        wr(boiler_limit_pkg::OFS_HW_LIM, 32'h0000_00B4);
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0003);
        rd_chk(boiler_limit_pkg::OFS_CTRL, 32'h0000_0003, 2'h0);
        // No byte lane enabled: the control word must not move
        wstrb <= 4'h0;
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_00FF);
        wstrb <= 4'hF;
        rd_chk(boiler_limit_pkg::OFS_CTRL, 32'h0000_0003, 2'h0);
        temps.hot_water <= 12'h0B3;
        settle;
        chk({rhold, hw_off, safety, susp}, 4'h2);
        temps.hot_water <= 12'h0B4;
        settle;
        chk({rhold, hw_off, safety, susp}, 4'hE);
        rd_chk(boiler_limit_pkg::OFS_STATUS, 32'h0000_0005, 2'h0);
        temps.hot_water <= 12'h0AF;
        settle;
        chk({rhold, hw_off, safety, susp}, 4'hE);
        temps.hot_water <= 12'h0AE;
        settle;
        chk({rhold, hw_off, safety, susp}, 4'h2);
    endtask : t_hw_recycle

    task automatic t_hw_suspend;
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0005);
        temps.hot_water <= 12'h0C8;
        settle;
        chk({rhold, hw_off, safety, susp}, 4'h5);
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0000);
        settle;
        chk({rhold, hw_off, safety, susp}, 4'h0);
        temps.hot_water <= 12'h064;
    endtask : t_hw_suspend

    task automatic t_heat_ac;
        wr(boiler_limit_pkg::OFS_AC_SP, 32'h0078_0064);
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0028);
        settle;
        chk({req, sel_hw, heat_off}, 3'h5);
        settle;
        chk(apply, 1'b1);
        other_ovr <= 1'b1;
        settle;
        chk(apply, 1'b0);
        preq.frost_heat <= 1'b1;
        settle;
        chk(heat_off, 1'b0);
        preq <= '0;
        firing <= 1'b0;
        settle;
        chk(req, 1'b0);
        firing <= 1'b1;
        settle;
        temps.outlet <= 12'h067;
        temps.central_src <= 12'h067;
        settle;
        chk({req, heat_off}, 2'h3);
        temps.outlet <= 12'h068;
        temps.central_src <= 12'h068;
        settle;
        chk({req, heat_off}, 2'h0);
        other_ovr <= 1'b0;
    endtask : t_heat_ac

    task automatic t_hw_ac;
        src <= boiler_limit_pkg::SRC_HOTWATER;
        temps.outlet <= 12'h064;
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0050);
        settle;
        chk({req, sel_hw, hw_off}, 3'h7);
        preq.frost_hw <= 1'b1;
        settle;
        chk(hw_off, 1'b0);
        preq <= '0;
        temps.outlet <= 12'h07B;
        settle;
        chk(req, 1'b1);
        temps.outlet <= 12'h07C;
        settle;
        chk({req, hw_off}, 2'h0);
    endtask : t_hw_ac

    // Raise the outlet by 3 each sample until an alert shows: 30 per minute
    task automatic ramp;
        for (int i = 0; i < 8; i++) begin
            repeat (20) @(posedge clk_sys_i);
            if (seen_alert) break;
            temps.outlet <= temps.outlet + 12'h003;
        end
    endtask : ramp

    task automatic t_rise;
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0000);
        wr(boiler_limit_pkg::OFS_RISE, 32'h0200_000A);
        seen_alert <= 1'b0;
        ramp;
        chk(seen_alert, 1'b0);
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0080);
        ramp;
        chk(seen_alert, 1'b1);
        repeat (2) @(posedge clk_sys_i);
        chk(rhold, 1'b1);
        repeat (40) @(posedge clk_sys_i);
        chk(rhold, 1'b0);
    endtask : t_rise

    task automatic t_lockout;
        wr(boiler_limit_pkg::OFS_CTRL, 32'h0000_0001);
        temps.hot_water <= 12'h0C8;
        settle;
        chk({lockout, safety}, 2'h3);
        temps.hot_water <= 12'h064;
        settle;
        chk(lockout, 1'b1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        settle;
        chk(lockout, 1'b0);
        rd_chk(8'h20, 32'h0000_0000, 2'h2);
    endtask : t_lockout

    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid, seen_alert} = '0;
        temps = {12'h064, 12'h05A, 12'h05A};
        src = boiler_limit_pkg::SRC_CENTRAL;
        preq = '0;
        wstrb = 4'hF;
        firing = 1'b1;
        other_ovr = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_hw_recycle;
        t_hw_suspend;
        t_heat_ac;
        t_hw_ac;
        t_rise;
        t_lockout;
        report_and_stop;
    end

    // Whole run needs about 400 cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        report_and_stop;
    end
endmodule : boiler_limit_override_tb
`default_nettype wire
